// ===== rtl/lpcff_front_end.sv
// lpc / programmer-port front end of a byte-wide flash
`default_nettype none
module lpcff_front_end #(
  parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C  // arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_init_n,
  input wire logic i_programmer_port_mode,
  input wire logic i_frame_n,
  input wire logic i_chip_enable_n,
  input wire logic [3:0] i_lad,
  output logic [3:0] o_lad,
  output logic o_lad_oe,
  input wire logic [3:0] i_strap_code,
  input wire logic i_top_area_lock_n,
  input wire logic i_write_protect_n,
  input wire logic [10:0] i_pp_addr,
  input wire logic i_pp_row_sel,
  input wire logic i_pp_latch,
  input wire logic [7:0] i_pp_data,
  output logic [7:0] o_pp_data,
  output logic o_pp_data_oe,
  input wire logic i_pp_read,
  input wire logic i_pp_write,
  input wire logic i_id_mode,
  input wire logic [7:0] i_array_data,
  input wire logic i_array_busy,
  output logic [19:0] o_addr,
  output logic o_mem_space,
  output logic o_read_req,
  output logic o_write_req,
  output logic [7:0] o_write_data,
  output logic o_write_blocked,
  output logic o_abort_pe,
  output logic o_standby
);
  ////////////////////////////////////////////////////////////////////////////
  // reset: both pins combined, released through two flops
  logic rst_comb_n;
  logic rst_meta;
  logic rst_n;
  assign rst_comb_n = i_nrst & i_init_n;
  always_ff @(posedge i_clock or negedge rst_comb_n) begin
    if (!rst_comb_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, a change counts when stages two and three agree
  // lad, frame and chip enable share this clock: a filter on them would eat nibbles
  localparam int SW = 3;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] sv;
  logic [SW-1:0] raw;
  assign raw = {i_programmer_port_mode, i_top_area_lock_n, i_write_protect_n};
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      sv <= '1;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      for (int k = 0; k < SW; k++) begin
        if (s2[k] == s3[k]) begin
          sv[k] <= s3[k];
        end
      end
    end
  end
  logic [3:0] lad;
  logic frame_n;
  logic ce_n;
  logic pp_mode;
  logic tbl_n;
  logic wp_n;
  assign lad = i_lad;
  assign frame_n = i_frame_n;
  assign ce_n = i_chip_enable_n;
  assign pp_mode = sv[2];
  assign tbl_n = sv[1];
  assign wp_n = sv[0];
  // mode taken once the synchroniser holds real pin values; the system holds it fixed anyway
  logic pp_sel;
  logic mode_taken;
  logic [lpcff_pkg::SYNC_FILL-1:0] sync_fill;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pp_sel <= 1'b0;
      mode_taken <= 1'b0;
      sync_fill <= '0;
    end else begin
      sync_fill <= {sync_fill[lpcff_pkg::SYNC_FILL-2:0], 1'b1};
      if (sync_fill[lpcff_pkg::SYNC_FILL-1] && !mode_taken) begin
        pp_sel <= pp_mode;
        mode_taken <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lpc target state machine
  lpcff_pkg::lpcff_state_e state;
  logic [3:0] start_val;
  logic frame_d;
  logic ce_at_frame;
  logic is_write;
  logic [2:0] nib_cnt;
  logic [31:0] addr;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic hit;
  logic frame_end;
  logic [31:0] full_addr;
  assign frame_end = !frame_d && frame_n;
  assign full_addr = {addr[27:0], lad};

  always_comb begin
    hit = 1'b1;
    if (full_addr[lpcff_pkg::AHI_TOP:lpcff_pkg::AHI_BOT] != lpcff_pkg::AHI_ONES
        && full_addr[lpcff_pkg::AHI_TOP:lpcff_pkg::AHI_BOT] != lpcff_pkg::AHI_ZERO) begin
      hit = 1'b0;
    end
    if (full_addr[lpcff_pkg::AHI_TOP:lpcff_pkg::AHI_BOT] == lpcff_pkg::AHI_ZERO) begin
      // low window is the boot part's memory only
      hit = (full_addr[lpcff_pkg::LOW_WIN_TOP:lpcff_pkg::LOW_WIN_BOT] == lpcff_pkg::LOW_WIN)
            && (i_strap_code == 4'h0);
    end else if (full_addr[lpcff_pkg::ID_HI_TOP:lpcff_pkg::ID_HI_BOT] != i_strap_code[3:2]
                 || full_addr[lpcff_pkg::ID_LO_TOP:lpcff_pkg::ID_LO_BOT] != i_strap_code[1:0]) begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_d <= 1'b1;
      start_val <= 4'hF;
    end else begin
      frame_d <= frame_n;
      if (!frame_n) begin
        start_val <= lad;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ce_at_frame <= 1'b0;
    end else if (frame_d && !frame_n) begin
      ce_at_frame <= !ce_n;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= lpcff_pkg::LPCFF_IDLE;
      is_write <= 1'b0;
      nib_cnt <= 3'h0;
      addr <= 32'h0;
      wr_byte <= 8'h0;
    end else if (pp_sel || !frame_n) begin
      state <= lpcff_pkg::LPCFF_IDLE;
    end else begin
      unique case (state)
        lpcff_pkg::LPCFF_IDLE: begin
          if (frame_end && start_val == lpcff_pkg::START_MEM && ce_at_frame) begin
            // the first nibble after frame release is the cycle type
            if (lad[lpcff_pkg::CYC_HI:lpcff_pkg::CYC_LO] == lpcff_pkg::CYC_MEM) begin
              is_write <= lad[lpcff_pkg::CYC_DIR];
              nib_cnt <= 3'h0;
              state <= lpcff_pkg::LPCFF_ADDR;
            end else begin
              state <= lpcff_pkg::LPCFF_SKIP;
            end
          end
        end
        lpcff_pkg::LPCFF_CYC: state <= lpcff_pkg::LPCFF_ADDR;
        lpcff_pkg::LPCFF_ADDR: begin
          addr <= full_addr;
          nib_cnt <= nib_cnt + 3'h1;
          if (nib_cnt == lpcff_pkg::ADDR_NIBBLES) begin
            if (!hit) begin
              state <= lpcff_pkg::LPCFF_SKIP;
            end else if (is_write) begin
              state <= lpcff_pkg::LPCFF_WDATA_LO;
            end else begin
              state <= lpcff_pkg::LPCFF_TAR0;
            end
          end
        end
        lpcff_pkg::LPCFF_WDATA_LO: begin
          wr_byte[3:0] <= lad;
          state <= lpcff_pkg::LPCFF_WDATA_HI;
        end
        lpcff_pkg::LPCFF_WDATA_HI: begin
          wr_byte[7:4] <= lad;
          state <= lpcff_pkg::LPCFF_TAR0;
        end
        lpcff_pkg::LPCFF_TAR0: state <= lpcff_pkg::LPCFF_TAR1;
        lpcff_pkg::LPCFF_TAR1: state <= lpcff_pkg::LPCFF_SYNC;
        lpcff_pkg::LPCFF_SYNC: state <= is_write ? lpcff_pkg::LPCFF_RTAR0 : lpcff_pkg::LPCFF_RDATA_LO;
        lpcff_pkg::LPCFF_RDATA_LO: state <= lpcff_pkg::LPCFF_RDATA_HI;
        lpcff_pkg::LPCFF_RDATA_HI: state <= lpcff_pkg::LPCFF_RTAR0;
        lpcff_pkg::LPCFF_RTAR0: state <= lpcff_pkg::LPCFF_RTAR1;
        lpcff_pkg::LPCFF_RTAR1: state <= lpcff_pkg::LPCFF_IDLE;
        lpcff_pkg::LPCFF_SKIP: state <= lpcff_pkg::LPCFF_SKIP;
        default: state <= lpcff_pkg::LPCFF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programmer port address capture
  logic [lpcff_pkg::ADDR_BITS-1:0] pp_addr;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pp_addr <= '0;
    end else if (pp_sel && i_pp_latch) begin
      if (i_pp_row_sel) begin
        pp_addr[lpcff_pkg::ROW_BITS-1:0] <= i_pp_addr;
      end else begin
        pp_addr[lpcff_pkg::ADDR_BITS-1:lpcff_pkg::ROW_BITS] <= i_pp_addr[8:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array request, read data and protection
  logic [19:0] cur_addr;
  logic cur_mem;
  logic prot;
  assign cur_addr = pp_sel ? pp_addr : addr[lpcff_pkg::BYTE_TOP:0];
  assign cur_mem = pp_sel ? 1'b1 : addr[lpcff_pkg::SPACE_BIT];
  always_comb begin
    // the two locks act on disjoint areas and never on each other
    if (cur_addr[lpcff_pkg::TOP_AREA_TOP:lpcff_pkg::TOP_AREA_BOT] == lpcff_pkg::TOP_AREA) begin
      prot = !tbl_n;
    end else begin
      prot = !wp_n;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_addr <= 20'h0;
      o_mem_space <= 1'b0;
      o_read_req <= 1'b0;
      o_write_req <= 1'b0;
      o_write_data <= 8'h0;
      o_write_blocked <= 1'b0;
    end else begin
      o_addr <= cur_addr;
      o_mem_space <= cur_mem;
      o_read_req <= pp_sel ? i_pp_read : (state == lpcff_pkg::LPCFF_TAR0 && !is_write);
      o_write_req <= 1'b0;
      o_write_blocked <= 1'b0;
      if ((pp_sel && i_pp_write) || (!pp_sel && state == lpcff_pkg::LPCFF_WDATA_HI && frame_n)) begin
        o_write_data <= pp_sel ? i_pp_data : {lad, wr_byte[3:0]};
        // protection is sampled at the request; holding it steady is the system's job
        o_write_req <= !(prot && cur_mem);
        o_write_blocked <= prot && cur_mem;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte <= 8'h0;
    end else if (i_id_mode && cur_addr == lpcff_pkg::ID_MFR_ADDR) begin
      rd_byte <= MFR_CODE;
    end else if (i_id_mode && cur_addr == lpcff_pkg::ID_DEV_ADDR) begin
      rd_byte <= DEV_CODE;
    end else begin
      rd_byte <= i_array_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_lad <= lpcff_pkg::TAR_ONES;
      o_lad_oe <= 1'b0;
      o_pp_data <= 8'h0;
      o_pp_data_oe <= 1'b0;
    end else begin
      o_pp_data <= rd_byte;
      o_pp_data_oe <= pp_sel && i_pp_read;
      o_lad_oe <= 1'b0;
      o_lad <= lpcff_pkg::TAR_ONES;
      if (!pp_sel && frame_n) begin
        unique case (state)
          lpcff_pkg::LPCFF_TAR1: begin
            o_lad <= lpcff_pkg::SYNC_READY;
            o_lad_oe <= 1'b1;
          end
          lpcff_pkg::LPCFF_SYNC: begin
            o_lad <= is_write ? lpcff_pkg::TAR_ONES : rd_byte[3:0];
            o_lad_oe <= 1'b1;
          end
          lpcff_pkg::LPCFF_RDATA_LO: begin
            o_lad <= rd_byte[7:4];
            o_lad_oe <= 1'b1;
          end
          lpcff_pkg::LPCFF_RDATA_HI: begin
            o_lad <= lpcff_pkg::TAR_ONES;
            o_lad_oe <= 1'b1;
          end
          default: begin
            o_lad_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset abort of program/erase, and standby
  logic [1:0] lat_cnt;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt <= lpcff_pkg::RESET_LATENCY;
      o_abort_pe <= 1'b0;
    end else if (lat_cnt != 2'h0) begin
      lat_cnt <= lat_cnt - 2'h1;
      o_abort_pe <= (lat_cnt == 2'h1) && i_array_busy;
    end else begin
      o_abort_pe <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_standby <= 1'b0;
    end else begin
      o_standby <= !i_array_busy && ce_n && frame_n && state == lpcff_pkg::LPCFF_IDLE;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/lpcff_pkg.sv
// constants and types of the flash interface front end
// Functional notes
// - programmer port runs when mode select is high, lpc target when low
// - programmer mode takes 11-bit multiplexed address and 8-bit two-way data
// - row phase gives internal bits 10:0, column phase the bits above
// - data lines sampled while frame low; last value at frame release is start
// - only start code zero is valid; then cycle type, then address nibbles
// - address phase carries 32 bits, one nibble per clock
// - write data follows address; reads insert turnaround and sync first
// - every operation ends with two-clock turnaround back to host
// - bits 31:25 all ones or zeros; bit 22 memory/register; 19:0 byte address
// - address bits 24:23 and 21:20 match strap bits 3:2 and 1:0
// - decode only top 32 MB and the 000E0000-000FFFFF window
// - standby only when writes done, chip enable high and frame inactive
// - frame assertion mid-cycle aborts it and returns to start watch
// - top lock low blocks program/erase of top 16 sectors, 64 KB
// - write protect low blocks all other sectors, independent of top lock
// - either reset input low resets the device identically
// - reset during read deselects and floats the lpc data lines
// - reset during program/erase aborts it after a latency
// - identification reads give manufacturer at 0000H, device code at 0001H
// - cycle type bits 3:2 are 01; bit 1 write; bit 0 reserved
// - read: sync 0000, data low nibble then high, then turnaround
`default_nettype none
package lpcff_pkg;
  localparam logic [3:0] START_MEM = 4'h0;
  localparam logic [1:0] CYC_MEM = 2'h1;
  localparam int CYC_HI = 3;
  localparam int CYC_LO = 2;
  localparam int CYC_DIR = 1;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] TAR_ONES = 4'hF;
  localparam logic [2:0] ADDR_NIBBLES = 3'h7;
  localparam int AHI_TOP = 31;
  localparam int AHI_BOT = 25;
  localparam logic [6:0] AHI_ONES = 7'h7F;
  localparam logic [6:0] AHI_ZERO = 7'h00;
  localparam int SPACE_BIT = 22;
  localparam int ID_HI_TOP = 24;
  localparam int ID_HI_BOT = 23;
  localparam int ID_LO_TOP = 21;
  localparam int ID_LO_BOT = 20;
  localparam int BYTE_TOP = 19;
  localparam int LOW_WIN_TOP = 31;
  localparam int LOW_WIN_BOT = 17;
  localparam logic [14:0] LOW_WIN = 15'h0007;
  localparam int TOP_AREA_TOP = 19;
  localparam int TOP_AREA_BOT = 16;
  localparam logic [3:0] TOP_AREA = 4'hF;
  localparam int ROW_BITS = 11;
  localparam int ADDR_BITS = 20;
  localparam logic [19:0] ID_MFR_ADDR = 20'h00000;
  localparam logic [19:0] ID_DEV_ADDR = 20'h00001;
  localparam logic [1:0] RESET_LATENCY = 2'h3;
  localparam int SYNC_FILL = 4;
  typedef enum logic [3:0] {
    LPCFF_IDLE, LPCFF_CYC, LPCFF_ADDR, LPCFF_WDATA_LO, LPCFF_WDATA_HI, LPCFF_TAR0,
    LPCFF_TAR1, LPCFF_SYNC, LPCFF_RDATA_LO, LPCFF_RDATA_HI, LPCFF_RTAR0, LPCFF_RTAR1,
    LPCFF_SKIP
  } lpcff_state_e;
endpackage
`default_nettype wire

// ===== sim/lpcff_front_end_checker.sv
// port-level assertions for the lpc flash front end
`default_nettype none
module lpcff_front_end_checker (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_init_n,
  input wire logic i_programmer_port_mode,
  input wire logic i_top_area_lock_n,
  input wire logic i_write_protect_n,
  input wire logic i_pp_read,
  input wire logic [3:0] o_lad,
  input wire logic o_lad_oe,
  input wire logic [19:0] o_addr,
  input wire logic o_read_req,
  input wire logic o_write_req,
  input wire logic o_write_blocked,
  input wire logic o_pp_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  AST_SYNC_FIRST: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    $rose(o_lad_oe) |-> o_lad == 4'h0) else $error("drive opened without sync");
  AST_TAR_END: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    $fell(o_lad_oe) |-> $past(o_lad) == 4'hF) else $error("drive ended without turnaround");
  // reset is asynchronous, so the lines are already quiet at the next edge
  AST_RESET_QUIET: assert property (@(posedge i_clock)
    (!i_nrst || !i_init_n) |-> !o_lad_oe && !o_read_req && !o_write_req) else $error("active during reset");
  AST_PP_NO_LPC: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    i_programmer_port_mode |-> !o_lad_oe) else $error("lpc drive in programmer mode");
  AST_PP_OE: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    i_programmer_port_mode && $past(i_pp_read) |-> o_pp_data_oe) else $error("pp data not driven");
  AST_TOP_LOCK: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    o_write_req && o_addr[19:16] == 4'hF |-> i_top_area_lock_n) else $error("top area written while locked");
  AST_WP: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    o_write_req && o_addr[19:16] != 4'hF |-> i_write_protect_n) else $error("sector written while protected");
  AST_REQ_EXCL: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    !(o_write_req && o_write_blocked)) else $error("write both issued and blocked");
  AST_RD_PULSE: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_init_n)
    o_read_req |=> !o_read_req ##1 !o_read_req) else $error("read request not a single pulse");
endmodule
`default_nettype wire

// ===== sim/lpcff_host_model.sv
// behavioural lpc host that runs frames into the front end
`default_nettype none
module lpcff_host_model (
  input wire logic i_clock,
  input wire logic [3:0] i_dev_lad,
  input wire logic i_dev_lad_oe,
  output logic o_frame_n,
  output logic o_chip_enable_n,
  output logic [3:0] o_lad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lad_q = 4'hF;
  logic drv = 1'b0;
  logic [3:0] pat = 4'h0;
  initial begin
    o_frame_n = 1'b1;
    o_chip_enable_n = 1'b1;
  end
  // a released line never keeps its last value
  always @(posedge i_clock) pat <= pat + 4'h1;
  assign o_lad = drv ? lad_q : pat;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [3:0] v, input logic f);
    @(posedge i_clock);
    o_frame_n <= f;
    lad_q <= v;
    drv <= 1'b1;
  endtask
  task automatic xfer(input logic wr, input logic [3:0] st, input logic [31:0] a, input logic [7:0] wd,
                      input int ab_at, output logic [7:0] rd, output logic seen);
    int i;
    logic ab;
    seen = 1'b0;
    ab = 1'b0;
    rd = 8'h00;
    @(posedge i_clock);
    o_chip_enable_n <= 1'b0;
    put(4'h9, 1'b0);
    put(st, 1'b0);
    put({2'b01, wr, 1'b0}, 1'b1);
    for (i = 0; i < 8 && !ab; i++) begin
      if (i == ab_at) begin
        put(4'hF, 1'b0);
        ab = 1'b1;
      end else begin
        put(a[31 - 4 * i -: 4], 1'b1);
      end
    end
    if (!ab) begin
      if (wr) begin
        put(wd[3:0], 1'b1);
        put(wd[7:4], 1'b1);
      end
      put(4'hF, 1'b1);
      @(posedge i_clock);
      drv <= 1'b0;
      for (i = 0; i < 40 && !seen; i++) begin
        @(negedge i_clock);
        seen = i_dev_lad_oe && i_dev_lad == 4'h0;
      end
      if (seen && !wr) begin
        @(negedge i_clock);
        rd[3:0] = i_dev_lad;
        @(negedge i_clock);
        rd[7:4] = i_dev_lad;
      end
      for (i = 0; i < 8 && i_dev_lad_oe; i++) @(negedge i_clock);
    end
    @(posedge i_clock);
    o_frame_n <= 1'b1;
    drv <= 1'b0;
    o_chip_enable_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_lpc_flash_front_end.sv
// self-checking bench of the lpc flash front end
`default_nettype none
`define CHK(nm, got, ex) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
  $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module test_lpc_flash_front_end;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h96; // arbitrary value
  localparam logic [7:0] DEV = 8'h69; // arbitrary value
  logic clk = 1'b0, nrst = 1'b1, init_n = 1'b1, mode = 1'b0, tbl_n = 1'b1, wp_n = 1'b1, id_mode = 1'b0;
  logic row_sel = 1'b0, latch = 1'b0, pp_rd = 1'b0, pp_wr = 1'b0, busy = 1'b0, seen, bl;
  logic [3:0] strap = 4'h6;
  logic [10:0] pp_addr = 11'h000;
  logic [7:0] pp_din = 8'h00, arr = 8'h00, rd, d, last_wd;
  logic [19:0] b, last_addr, last_raddr;
  logic last_mem;
  int seed = 32'h55167bf3, n_fail = 0, n_compared = 0, wr_n = 0, blk_n = 0, rd_n = 0, ab_n = 0, k, w0, b0, r0;
  wire logic frame_n, ce_n, dut_oe, pp_oe, mem_sp, rreq, wreq, wblk, abort, stby;
  wire logic [3:0] host_lad, dut_lad, bus_lad;
  wire logic [7:0] pp_dout, wdat;
  wire logic [19:0] addr;
  always #10 clk = ~clk;
  assign bus_lad = dut_oe ? dut_lad : host_lad;
  lpcff_host_model lpcff_host_model_inst (.i_clock(clk), .i_dev_lad(dut_lad), .i_dev_lad_oe(dut_oe),
    .o_frame_n(frame_n), .o_chip_enable_n(ce_n), .o_lad(host_lad));
  lpcff_front_end #(.MFR_CODE(MFR), .DEV_CODE(DEV)) lpcff_front_end_inst (.i_clock(clk), .i_nrst(nrst),
    .i_init_n(init_n), .i_programmer_port_mode(mode), .i_frame_n(frame_n), .i_chip_enable_n(ce_n),
    .i_lad(bus_lad), .o_lad(dut_lad), .o_lad_oe(dut_oe), .i_strap_code(strap), .i_top_area_lock_n(tbl_n),
    .i_write_protect_n(wp_n), .i_pp_addr(pp_addr), .i_pp_row_sel(row_sel), .i_pp_latch(latch),
    .i_pp_data(pp_din), .o_pp_data(pp_dout), .o_pp_data_oe(pp_oe), .i_pp_read(pp_rd), .i_pp_write(pp_wr),
    .i_id_mode(id_mode), .i_array_data(arr), .i_array_busy(busy), .o_addr(addr), .o_mem_space(mem_sp),
    .o_read_req(rreq), .o_write_req(wreq), .o_write_data(wdat), .o_write_blocked(wblk), .o_abort_pe(abort),
    .o_standby(stby));
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (wreq === 1'b1) begin
      wr_n++;
      last_addr = addr;
      last_wd = wdat;
    end
    if (rreq === 1'b1) begin
      rd_n++;
      last_raddr = addr;
      last_mem = mem_sp;
    end
    if (wblk === 1'b1) blk_n++;
    if (abort === 1'b1) ab_n++;
  end
  function automatic logic [31:0] mk(input logic [6:0] hi, input logic [3:0] id, input logic [19:0] ba);
    return {hi, id[3:2], 1'b1, id[1:0], ba};
  endfunction
  task automatic lx(input logic wr, input logic [3:0] st, input logic [31:0] a, input logic [7:0] wd, input int ab);
    lpcff_host_model_inst.xfer(wr, st, a, wd, ab, rd, seen);
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    n_fail++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // a real falling edge once every process waits on it
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    for (k = 0; k < 6; k++) begin
      b = (k == 0) ? 20'hFFFFF : 20'($random(seed));
      d = 8'($random(seed));
      arr <= d;
      lx(1'b0, 4'h0, mk(7'h7F, strap, b), 8'h00, 9);
      `CHK("rsync", seen, 1'b1)
      `CHK("rdata", rd, d)
      `CHK("raddr", {last_mem, last_raddr}, {1'b1, b})
    end
    id_mode <= 1'b1;
    for (k = 0; k < 2; k++) begin
      lx(1'b0, 4'h0, mk(7'h7F, strap, 20'(k)), 8'h00, 9);
      `CHK("ident", rd, k ? DEV : MFR)
    end
    id_mode <= 1'b0;
    for (k = 0; k < 8; k++) begin
      {tbl_n, wp_n} <= 2'(k);
      // protection settles long before the write starts
      repeat (6) @(posedge clk);
      b = {k[2] ? 4'hF : 4'h3, 16'($random(seed))};
      d = 8'($random(seed));
      bl = k[2] ? !k[1] : !k[0];
      w0 = wr_n;
      b0 = blk_n;
      lx(1'b1, 4'h0, mk(7'h7F, strap, b), d, 9);
      `CHK("wsync", seen, 1'b1)
      `CHK("wblk", blk_n - b0, int'(bl))
      `CHK("wreq", wr_n - w0, int'(!bl))
      if (!bl) `CHK("wdata", {last_addr, last_wd}, {b, d})
    end
    tbl_n <= 1'b1;
    wp_n <= 1'b1;
    for (k = 0; k < 5; k++) begin
      r0 = rd_n;
      lx(1'b0, k == 3 ? 4'h5 : 4'h0, k == 0 ? mk(7'h00, strap, 20'h0) : k == 1 ? mk(7'h3F, strap, 20'h0) :
         k == 4 ? mk(7'h7F, 4'h9, 20'h0) : mk(7'h7F, strap, 20'h0), 8'h00, k == 2 ? 3 : 9);
      `CHK("msync", seen, 1'b0)
      `CHK("mreq", rd_n, r0)
    end
    busy <= 1'b1;
    fork
      lx(1'b0, 4'h0, mk(7'h7F, strap, 20'h12345), 8'h00, 9);
      begin
        for (k = 0; k < 60 && dut_oe !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
        r0 = ab_n;
        init_n <= 1'b0;
        @(negedge clk);
        `CHK("rst_oe", dut_oe, 1'b0)
        @(posedge clk);
        init_n <= 1'b1;
      end
    join
    repeat (10) @(posedge clk);
    `CHK("abort", ab_n - r0, 1)
    busy <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("stby", stby, 1'b1)
    busy <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("stby_busy", stby, 1'b0)
    busy <= 1'b0;
    mode <= 1'b1;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    for (k = 0; k < 3; k++) begin
      b = 20'($random(seed));
      d = 8'($random(seed));
      w0 = wr_n;
      pp_addr <= b[10:0];
      row_sel <= 1'b1;
      latch <= 1'b1;
      @(posedge clk);
      pp_addr <= {2'b00, b[19:11]};
      row_sel <= 1'b0;
      @(posedge clk);
      latch <= 1'b0;
      pp_din <= d;
      arr <= ~d;
      pp_wr <= 1'b1;
      @(posedge clk);
      pp_wr <= 1'b0;
      pp_rd <= 1'b1;
      @(posedge clk);
      pp_rd <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("pp_wr", {last_addr, last_wd}, {b, d})
      `CHK("pp_n", wr_n - w0, 1)
      `CHK("pp_rd", pp_dout, ~d)
    end
    lx(1'b0, 4'h0, mk(7'h7F, strap, 20'h00010), 8'h00, 9);
    `CHK("pp_lpc", seen, 1'b0)
    summarize();
  end
endmodule
bind lpcff_front_end lpcff_front_end_checker lpcff_front_end_checker_inst (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_init_n(i_init_n), .i_programmer_port_mode(i_programmer_port_mode), .i_top_area_lock_n(i_top_area_lock_n),
  .i_write_protect_n(i_write_protect_n), .i_pp_read(i_pp_read), .o_lad(o_lad), .o_lad_oe(o_lad_oe),
  .o_addr(o_addr), .o_read_req(o_read_req), .o_write_req(o_write_req), .o_write_blocked(o_write_blocked),
  .o_pp_data_oe(o_pp_data_oe));
`default_nettype wire
